// ---- sclkm_pkg.sv ----
// Notes on behaviour
// - two-stage prescaler feeds twenty-one-stage divider
// - prescaler and divider cleared on reset, stop
// - stage seven source from mode and selects
// - slow modes feed low clock into stage seven
// - warm-up from fast feeds stage six onward
// - machine cycle is four one-clock states
// - single clock: fast oscillator only, pins ports
// - reset leaves single-clock fast run
// - doze request halts core; interrupt wakes it
// - doze wake takes interrupt if master enabled
// - timing halt gates all but time base
// - time base falling edge ends deep doze
// - deep doze ignores tbase enable; service needs three
// - tbase enable at entry sets latch on return
// - dual clock: both oscillators, main clock by mode
// - machine cycle four periods of chosen source
// - dual fast run clocks core from fast clock
// - core select and fast enable steer dual modes
// - slow modes stop prescaler and stages one-six
`default_nettype none
package sclkm_pkg;
    // register word indices
    localparam logic [1:0] SCLKM_SYS_CTRL_TWO = 2'h0;
    localparam logic [1:0] SCLKM_TBASE_CTRL = 2'h1;
    localparam logic [1:0] SCLKM_STATUS = 2'h2;
    // system_control_two fields
    localparam int SCLKM_CORE_SEL_BIT = 0;
    localparam int SCLKM_DOZE_BIT = 1;
    localparam int SCLKM_HALT_BIT = 2;
    localparam int SCLKM_FAST_EN_BIT = 3;
    localparam int SCLKM_SLOW_EN_BIT = 4;
    // tbase_control fields
    localparam int SCLKM_TB_EN_BIT = 0;
    localparam int SCLKM_TB_SEL_LO = 1;
    localparam int SCLKM_S7_SEL_BIT = 4;
    // status fields
    localparam int SCLKM_ST_MODE_LO = 0;
    localparam int SCLKM_ST_PHASE_LO = 4;
    // reset values
    localparam logic SCLKM_FAST_EN_RST = 1'b1;
    localparam logic SCLKM_SLOW_EN_RST = 1'b0;
    localparam logic [2:0] SCLKM_TB_SEL_RST = 3'h0;
    // timing
    localparam int SCLKM_PRE_W = 2;
    localparam int SCLKM_DIV_W = 21;
    localparam int SCLKM_LOW_STAGES = 6;
    localparam int SCLKM_WARM_BIT_DEF = 20;
    localparam logic [1:0] SCLKM_LAST_PHASE = 2'h3;

    typedef enum logic [3:0] {
        fast_run_single = 4'h0,
        fast_doze_single = 4'h1,
        deep_doze_single = 4'h3,
        fast_run_dual = 4'h2,
        fast_doze_dual = 4'h6,
        slow_run_dual = 4'h7,
        slow_only_run = 4'h5,
        slow_doze_only = 4'h4,
        stop_held = 4'hc,
        stop_warm = 4'hd
    } sclkm_mode_t;

    // divider stage watched by each time-base source select
    function automatic logic [4:0] sclkm_tb_stage(input logic [2:0] sel);
        logic [4:0] r;
        r = 5'h14;
        case (sel)
            3'h0: r = 5'h14;
            3'h1: r = 5'h12;
            3'h2: r = 5'h10;
            3'h3: r = 5'h0e;
            3'h4: r = 5'h0c;
            3'h5: r = 5'h0a;
            3'h6: r = 5'h08;
            default: r = 5'h06;
        endcase
        return r;
    endfunction

    function automatic logic sclkm_is_slow(input sclkm_mode_t m);
        return (m == slow_run_dual) || (m == slow_only_run) || (m == slow_doze_only);
    endfunction
endpackage
`default_nettype wire

// ---- sclkm_top.sv ----
`default_nettype none
module sclkm_top import sclkm_pkg::*; #(
    parameter int WARM_BIT = SCLKM_WARM_BIT_DEF
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // oscillator clocks, sampled
    input wire logic high_freq_clock_in,
    input wire logic low_freq_clock_in,
    // register port
    input wire logic [1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // core side events
    input wire logic irq_req_in,
    input wire logic master_irq_enable_in,
    input wire logic tbase_irq_individual_enable_in,
    input wire logic stop_req_in,
    input wire logic stop_release_in,
    // clock and mode outputs
    output logic main_tick_out,
    output logic [1:0] machine_state_out,
    output logic cycle_end_out,
    output logic core_run_out,
    output logic periph_run_out,
    output logic tbase_run_out,
    output logic fast_osc_on_out,
    output logic slow_osc_on_out,
    output logic slow_pins_port_out,
    output logic [SCLKM_DIV_W-1:0] divider_out,
    output logic [3:0] mode_out,
    // wake outputs
    output logic irq_take_out,
    output logic resume_next_out,
    output logic tbase_irq_latch_out
);
    sclkm_mode_t mode_q, mode_d;
    logic fc_prev_q, fs_prev_q;
    logic [SCLKM_PRE_W-1:0] pre_q;
    logic [SCLKM_DIV_W-1:0] div_q;
    logic core_sel_q, fast_en_q, slow_en_q, halt_q, doze_req_q;
    logic tb_en_q, s7_sel_q;
    logic [2:0] tb_sel_q;
    logic tb_prev_q, tb_at_entry_q, from_fast_q, clk_slow_q;
    logic [1:0] phase_q;
    logic [7:0] rdata_d;

    // edges of the sampled oscillators
    wire fc_tick = high_freq_clock_in & ~fc_prev_q;
    wire fs_tick = low_freq_clock_in & ~fs_prev_q;
    wire fs_fall = ~low_freq_clock_in & fs_prev_q;

    wire in_stop = (mode_q == stop_held);
    wire in_warm = (mode_q == stop_warm);
    wire mode_slow = sclkm_is_slow(mode_q);
    wire warm_slow = in_warm & ~from_fast_q;

    // prescaler and stages one to six halt in slow modes
    wire low_run = ~mode_slow & ~in_stop & ~warm_slow;
    wire pre_carry = low_run & fc_tick & (pre_q == {SCLKM_PRE_W{1'b1}});
    wire low_carry = pre_carry & (div_q[SCLKM_LOW_STAGES-1:0] == {SCLKM_LOW_STAGES{1'b1}});

    // stage seven input: slow modes force low clock, fast warm-up forces stage six
    wire s7_tick = (mode_slow | warm_slow) ? fs_tick :
                   in_warm ? low_carry :
                   (s7_sel_q ? fs_tick : low_carry);

    // STOP entry and release both wipe the chain
    wire stop_enter = (mode_d == stop_held) & ~in_stop;
    wire div_clear = stop_enter | (in_stop & stop_release_in);

    // deep doze wake on falling edge of selected time-base source
    wire [4:0] tb_idx = sclkm_tb_stage(tb_sel_q);
    wire tb_src = div_q[tb_idx];
    wire tb_fall = tb_prev_q & ~tb_src;

    wire warm_done = in_warm & div_q[WARM_BIT];
    wire run_state = (mode_q == fast_run_single) | (mode_q == fast_run_dual) |
                     (mode_q == slow_run_dual) | (mode_q == slow_only_run);
    wire doze_state = (mode_q == fast_doze_single) | (mode_q == fast_doze_dual) |
                      (mode_q == slow_doze_only);

    // main clock source: switch on a tick of the old source, or to fast on a low-clock fall with a fast tick,
    // the new source then starts a whole period, so no short state
    wire want_slow = mode_slow;
    wire cur_tick = clk_slow_q ? fs_tick : fc_tick;
    wire main_tick = cur_tick & ~in_stop & ~in_warm;
    wire core_runs = run_state;
    wire periph_runs = (run_state | doze_state) & ~in_stop & ~in_warm;

    // register writes
    wire wr_sys = reg_write_in & (reg_addr_in == SCLKM_SYS_CTRL_TWO);
    wire wr_tb = reg_write_in & (reg_addr_in == SCLKM_TBASE_CTRL);

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            fast_run_single: begin
                if (stop_req_in) begin
                    mode_d = stop_held;
                end else if (halt_q) begin
                    mode_d = deep_doze_single;
                end else if (doze_req_q) begin
                    mode_d = fast_doze_single;
                end else if (slow_en_q) begin
                    mode_d = fast_run_dual;
                end
            end
            fast_doze_single: begin
                if (irq_req_in) begin
                    mode_d = fast_run_single;
                end
            end
            deep_doze_single: begin
                if (tb_fall) begin
                    mode_d = fast_run_single;
                end
            end
            fast_run_dual: begin
                if (stop_req_in) begin
                    mode_d = stop_held;
                end else if (doze_req_q) begin
                    mode_d = fast_doze_dual;
                end else if (!slow_en_q) begin
                    mode_d = fast_run_single;
                end else if (core_sel_q) begin
                    mode_d = slow_run_dual;
                end
            end
            fast_doze_dual: begin
                if (irq_req_in) begin
                    mode_d = fast_run_dual;
                end
            end
            slow_run_dual: begin
                if (stop_req_in) begin
                    mode_d = stop_held;
                end else if (doze_req_q) begin
                    mode_d = slow_doze_only;
                end else if (!core_sel_q) begin
                    mode_d = fast_run_dual;
                end else if (!fast_en_q) begin
                    mode_d = slow_only_run;
                end
            end
            slow_only_run: begin
                if (stop_req_in) begin
                    mode_d = stop_held;
                end else if (doze_req_q) begin
                    mode_d = slow_doze_only;
                end else if (fast_en_q) begin
                    mode_d = slow_run_dual;
                end
            end
            slow_doze_only: begin
                if (irq_req_in) begin
                    mode_d = fast_en_q ? slow_run_dual : slow_only_run;
                end
            end
            stop_held: begin
                if (stop_release_in) begin
                    mode_d = stop_warm;
                end
            end
            stop_warm: begin
                if (warm_done) begin
                    mode_d = !from_fast_q ? slow_only_run : (slow_en_q ? fast_run_dual : fast_run_single);
                end
            end
            default: mode_d = fast_run_single;
        endcase
    end

    // register read mux
    always_comb begin
        rdata_d = 8'h00;
        if (reg_read_in) begin
            unique case (reg_addr_in)
                SCLKM_SYS_CTRL_TWO: begin
                    rdata_d[SCLKM_CORE_SEL_BIT] = core_sel_q;
                    rdata_d[SCLKM_HALT_BIT] = halt_q;
                    rdata_d[SCLKM_FAST_EN_BIT] = fast_en_q;
                    rdata_d[SCLKM_SLOW_EN_BIT] = slow_en_q;
                end
                SCLKM_TBASE_CTRL: begin
                    rdata_d[SCLKM_TB_EN_BIT] = tb_en_q;
                    rdata_d[SCLKM_TB_SEL_LO +: 3] = tb_sel_q;
                    rdata_d[SCLKM_S7_SEL_BIT] = s7_sel_q;
                end
                SCLKM_STATUS: begin
                    rdata_d[SCLKM_ST_MODE_LO +: 4] = mode_q;
                    rdata_d[SCLKM_ST_PHASE_LO +: 2] = phase_q;
                end
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_q <= fast_run_single;
            fc_prev_q <= 1'b0;
            fs_prev_q <= 1'b0;
            clk_slow_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            fc_prev_q <= high_freq_clock_in;
            fs_prev_q <= low_freq_clock_in;
            if (want_slow != clk_slow_q) begin
                // moving to fast switches on a low-clock rise, or on a low-clock fall that meets a fast tick
                if (clk_slow_q ? (fs_fall & fc_tick) | fs_tick : fc_tick) begin
                    clk_slow_q <= want_slow;
                end
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_q <= '0;
            div_q <= '0;
            tb_prev_q <= 1'b0;
        end else if (div_clear) begin
            pre_q <= '0;
            div_q <= '0;
            tb_prev_q <= 1'b0;
        end else begin
            if (low_run && fc_tick) begin
                pre_q <= pre_q + 2'h1;
            end
            if (pre_carry) begin
                div_q[SCLKM_LOW_STAGES-1:0] <= div_q[SCLKM_LOW_STAGES-1:0] + 6'h01;
            end
            if (s7_tick && !in_stop) begin
                div_q[SCLKM_DIV_W-1:SCLKM_LOW_STAGES] <= div_q[SCLKM_DIV_W-1:SCLKM_LOW_STAGES] + 15'h0001;
            end
            tb_prev_q <= tb_src;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            core_sel_q <= 1'b0;
            fast_en_q <= SCLKM_FAST_EN_RST;
            slow_en_q <= SCLKM_SLOW_EN_RST;
            tb_en_q <= 1'b0;
            tb_sel_q <= SCLKM_TB_SEL_RST;
            s7_sel_q <= 1'b0;
        end else begin
            if (wr_sys) begin
                core_sel_q <= reg_wdata_in[SCLKM_CORE_SEL_BIT];
                fast_en_q <= reg_wdata_in[SCLKM_FAST_EN_BIT];
                slow_en_q <= reg_wdata_in[SCLKM_SLOW_EN_BIT];
            end
            if (wr_tb) begin
                tb_en_q <= reg_wdata_in[SCLKM_TB_EN_BIT];
                tb_sel_q <= reg_wdata_in[SCLKM_TB_SEL_LO +: 3];
                s7_sel_q <= reg_wdata_in[SCLKM_S7_SEL_BIT];
            end
        end
    end

    // doze and halt requests; the halt field reads one until deep doze ends
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            doze_req_q <= 1'b0;
            halt_q <= 1'b0;
            tb_at_entry_q <= 1'b0;
            from_fast_q <= 1'b1;
        end else begin
            doze_req_q <= wr_sys & reg_wdata_in[SCLKM_DOZE_BIT] & run_state;
            if (mode_q == deep_doze_single && mode_d == fast_run_single) begin
                halt_q <= 1'b0;
            end else if (wr_sys && reg_wdata_in[SCLKM_HALT_BIT] && mode_q == fast_run_single) begin
                halt_q <= 1'b1;
            end
            if (mode_d == deep_doze_single && mode_q != deep_doze_single) begin
                tb_at_entry_q <= tb_en_q;
            end
            if (stop_enter) begin
                from_fast_q <= ~mode_slow;
            end
        end
    end

    // machine states S0..S3, one main clock each, counted only while the core runs
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_q <= 2'h0;
            cycle_end_out <= 1'b0;
            main_tick_out <= 1'b0;
        end else begin
            main_tick_out <= main_tick;
            cycle_end_out <= main_tick & core_runs & (phase_q == SCLKM_LAST_PHASE);
            if (main_tick && core_runs) begin
                phase_q <= phase_q + 2'h1;
            end
        end
    end

    // wake outcomes, one-cycle pulses
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_take_out <= 1'b0;
            resume_next_out <= 1'b0;
            tbase_irq_latch_out <= 1'b0;
        end else begin
            irq_take_out <= 1'b0;
            resume_next_out <= 1'b0;
            tbase_irq_latch_out <= 1'b0;
            if (doze_state && mode_d != mode_q) begin
                irq_take_out <= master_irq_enable_in;
                resume_next_out <= ~master_irq_enable_in;
            end
            if (mode_q == deep_doze_single && tb_fall) begin
                irq_take_out <= master_irq_enable_in & tbase_irq_individual_enable_in & tb_en_q;
                resume_next_out <= ~(master_irq_enable_in & tbase_irq_individual_enable_in & tb_en_q);
                tbase_irq_latch_out <= tb_at_entry_q;
            end
        end
    end

    // registered status outputs
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
            machine_state_out <= 2'h0;
            core_run_out <= 1'b0;
            periph_run_out <= 1'b0;
            tbase_run_out <= 1'b0;
            fast_osc_on_out <= 1'b0;
            slow_osc_on_out <= 1'b0;
            slow_pins_port_out <= 1'b1;
            divider_out <= '0;
            mode_out <= 4'h0;
        end else begin
            reg_rdata_out <= rdata_d;
            machine_state_out <= phase_q;
            core_run_out <= core_runs;
            periph_run_out <= periph_runs;
            tbase_run_out <= ~in_stop;
            fast_osc_on_out <= ~in_stop & (mode_q != slow_only_run) & (mode_q != slow_doze_only);
            slow_osc_on_out <= ~in_stop & (slow_en_q | mode_slow);
            slow_pins_port_out <= (mode_q == fast_run_single) | (mode_q == fast_doze_single) |
                                  (mode_q == deep_doze_single);
            divider_out <= div_q;
            mode_out <= mode_q;
        end
    end
endmodule
`default_nettype wire

// ---- sclkm_top_sva.sv ----
`default_nettype none
module sclkm_top_sva import sclkm_pkg::*; (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // watched outputs
    input wire logic [1:0] machine_state_out,
    input wire logic core_run_out,
    input wire logic periph_run_out,
    input wire logic tbase_run_out,
    input wire logic fast_osc_on_out,
    input wire logic slow_pins_port_out,
    input wire logic [SCLKM_DIV_W-1:0] divider_out,
    input wire logic [3:0] mode_out,
    input wire logic tbase_irq_latch_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    // two cycles in stop so the clear has landed
    sequence s_stop_two;
        (mode_out == stop_held) ##1 (mode_out == stop_held);
    endsequence
    sequence s_deep_exit;
        ($past(mode_out) == deep_doze_single) && (mode_out == fast_run_single);
    endsequence

    property p_boot;
        $past(rst_in) && !rst_in |-> ##1 (core_run_out && mode_out == fast_run_single);
    endproperty
    property p_state_step;
        $changed(machine_state_out) |-> machine_state_out == $past(machine_state_out) + 2'h1;
    endproperty
    property p_single_pins;
        !$past(rst_in) && $stable(mode_out) && (mode_out inside {fast_run_single, fast_doze_single,
            deep_doze_single}) |-> slow_pins_port_out && fast_osc_on_out;
    endproperty
    property p_doze;
        $stable(mode_out) && mode_out == fast_doze_single |-> !core_run_out && periph_run_out;
    endproperty
    property p_deep;
        $stable(mode_out) && mode_out == deep_doze_single |-> !core_run_out && !periph_run_out && tbase_run_out;
    endproperty
    property p_tbase_run;
        !$past(rst_in) && $stable(mode_out) && mode_out != stop_held |-> tbase_run_out;
    endproperty
    // latch pulse leads mode_out by one cycle
    property p_latch;
        tbase_irq_latch_out |-> ##1 s_deep_exit;
    endproperty
    property p_stop_clear;
        s_stop_two |-> divider_out == '0;
    endproperty
    property p_slow_low;
        $stable(mode_out) && (mode_out inside {slow_only_run, slow_doze_only}) |-> $stable(divider_out[5:0]);
    endproperty

    a_boot: assert property (p_boot) else $error("mode after reset wrong");
    a_state_step: assert property (p_state_step) else $error("machine state skipped");
    a_single_pins: assert property (p_single_pins) else $error("single clock pins wrong");
    a_doze: assert property (p_doze) else $error("doze run levels wrong");
    a_deep: assert property (p_deep) else $error("deep doze gating wrong");
    a_tbase_run: assert property (p_tbase_run) else $error("time base clock stopped");
    a_latch: assert property (p_latch) else $error("time base latch out of place");
    a_stop_clear: assert property (p_stop_clear) else $error("divider not cleared in stop");
    a_slow_low: assert property (p_slow_low) else $error("low stages run in slow mode");
endmodule
`default_nettype wire

// ---- sclkm_top_tb.sv ----
`default_nettype none
module sclkm_top_tb import sclkm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in, rst_in, high_freq_clock_in, low_freq_clock_in, reg_write_in, reg_read_in;
    logic irq_req_in, master_irq_enable_in, tbase_irq_individual_enable_in, stop_req_in, stop_release_in;
    logic [1:0] reg_addr_in, machine_state_out;
    logic [7:0] reg_wdata_in, reg_rdata_out, osc_cnt, v;
    logic main_tick_out, cycle_end_out, core_run_out, periph_run_out, tbase_run_out, fast_osc_on_out;
    logic slow_osc_on_out, slow_pins_port_out, irq_take_out, resume_next_out, tbase_irq_latch_out;
    logic [SCLKM_DIV_W-1:0] divider_out;
    logic [3:0] mode_out;
    int fails, cmp_count, tk, ce;

    sclkm_top #(.WARM_BIT(7)) uut (.mclk_in(mclk_in), .rst_in(rst_in), .high_freq_clock_in(high_freq_clock_in),
        .low_freq_clock_in(low_freq_clock_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
        .irq_req_in(irq_req_in), .master_irq_enable_in(master_irq_enable_in),
        .tbase_irq_individual_enable_in(tbase_irq_individual_enable_in), .stop_req_in(stop_req_in),
        .stop_release_in(stop_release_in), .main_tick_out(main_tick_out), .machine_state_out(machine_state_out),
        .cycle_end_out(cycle_end_out), .core_run_out(core_run_out), .periph_run_out(periph_run_out),
        .tbase_run_out(tbase_run_out), .fast_osc_on_out(fast_osc_on_out), .slow_osc_on_out(slow_osc_on_out),
        .slow_pins_port_out(slow_pins_port_out), .divider_out(divider_out), .mode_out(mode_out),
        .irq_take_out(irq_take_out), .resume_next_out(resume_next_out), .tbase_irq_latch_out(tbase_irq_latch_out));

    always #4 mclk_in = ~mclk_in;
    // fast source every 4 cycles, slow every 64: slow must stay far below mclk
    always @(posedge mclk_in) begin
        osc_cnt <= osc_cnt + 8'h01;
        high_freq_clock_in <= osc_cnt[1];
        low_freq_clock_in <= osc_cnt[5];
    end

    task automatic end_sim;
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // tick counts are off by one at window edges
    task automatic chk_rng(input string nm, input int exp, input int got);
        cmp_count++;
        if (got < exp - 1 || got > exp + 1) begin
            fails++;
            $display("wrong value %s expected %0d seen %0d", nm, exp, got);
        end
    endtask
    task automatic step;
        @(posedge mclk_in);
        #1;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge mclk_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge mclk_in);
        reg_read_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    task automatic wait_mode(input logic [3:0] m, input int n);
        for (int i = 0; i < n && mode_out !== m; i++) step;
        chk("mode_out", m, mode_out);
    endtask
    task automatic count(input int n);
        tk = 0;
        ce = 0;
        for (int i = 0; i < n; i++) begin
            step;
            if (main_tick_out === 1'b1) tk++;
            if (cycle_end_out === 1'b1) ce++;
        end
    endtask

    task automatic t_reset;
        step;
        chk("mode_out", fast_run_single, mode_out);
        chk("slow_pins_port_out", 1, slow_pins_port_out);
        chk("slow_osc_on_out", 0, slow_osc_on_out);
        rd(0, v);
        chk("sys ctrl two", 8'h08, v);
        rd(1, v);
        chk("tbase ctrl", 8'h00, v);
        wr(3, 8'hff);
        rd(3, v);
        chk("unmapped", 8'h00, v);
        rd(2, v);
        chk("status mode", 4'h0, v[3:0]);
    endtask
    task automatic t_fast_cycle;
        count(400);
        chk_rng("fast ticks", 100, tk);
        chk_rng("cycle ends", 25, ce);
    endtask
    task automatic t_doze(input logic mie);
        int hit;
        @(posedge mclk_in) master_irq_enable_in <= mie;
        wr(0, 8'h0a);
        wait_mode(fast_doze_single, 6);
        step;
        chk("core_run_out", 0, core_run_out);
        chk("periph_run_out", 1, periph_run_out);
        @(posedge mclk_in) irq_req_in <= 1'b1;
        hit = 0;
        for (int i = 0; i < 20 && hit == 0; i++) begin
            step;
            if ((mie ? irq_take_out : resume_next_out) === 1'b1) hit = 1;
        end
        chk("wake pulse", 1, hit);
        @(posedge mclk_in) irq_req_in <= 1'b0;
        step;
        chk("mode_out", fast_run_single, mode_out);
    endtask
    task automatic t_deep(input logic en);
        logic lat, tak;
        lat = 0;
        tak = 0;
        @(posedge mclk_in) master_irq_enable_in <= 1'b1;
        tbase_irq_individual_enable_in <= 1'b1;
        // select 7 watches the fastest stage so the wake comes within the loop limit
        wr(1, {4'h0, 3'h7, en});
        wr(0, 8'h0c);
        wait_mode(deep_doze_single, 6);
        step; step;
        chk("periph_run_out", 0, periph_run_out);
        chk("tbase_run_out", 1, tbase_run_out);
        for (int i = 0; i < 3000 && mode_out !== fast_run_single; i++) begin
            step;
            if (tbase_irq_latch_out === 1'b1) lat = 1;
            if (irq_take_out === 1'b1) tak = 1;
        end
        chk("mode_out", fast_run_single, mode_out);
        chk("latch pulse", en, lat);
        chk("irq take", en, tak);
        chk("core_run_out", 1, core_run_out);
    endtask
    task automatic t_stop;
        @(posedge mclk_in) stop_req_in <= 1'b1;
        @(posedge mclk_in) stop_req_in <= 1'b0;
        step; step; step;
        chk("mode_out", stop_held, mode_out);
        chk("divider_out", 0, divider_out);
        @(posedge mclk_in) stop_release_in <= 1'b1;
        @(posedge mclk_in) stop_release_in <= 1'b0;
        step;
        wait_mode(fast_run_single, 5000);
        count(50);
        chk_rng("warm exit ticks", 12, tk);
        @(posedge mclk_in) rst_in <= 1'b1;
        step;
        chk("divider_out", 0, divider_out);
        @(posedge mclk_in) rst_in <= 1'b0;
        step; step;
    endtask
    task automatic t_dual;
        int s7;
        wr(0, 8'h18);
        wait_mode(fast_run_dual, 10);
        step;
        chk("slow_osc_on_out", 1, slow_osc_on_out);
        chk("slow_pins_port_out", 0, slow_pins_port_out);
        count(400);
        chk_rng("dual fast ticks", 100, tk);
        // stage seven fed by the low clock once selected in dual fast run
        wr(1, 8'h10);
        step;
        s7 = divider_out[SCLKM_DIV_W-1:SCLKM_LOW_STAGES];
        count(640);
        chk_rng("stage seven ticks", 10, divider_out[SCLKM_DIV_W-1:SCLKM_LOW_STAGES] - s7);
        wr(0, 8'h19);
        wait_mode(slow_run_dual, 300);
        count(640);
        chk_rng("slow ticks", 10, tk);
        wr(0, 8'h11);
        wait_mode(slow_only_run, 300);
        step;
        chk("fast_osc_on_out", 0, fast_osc_on_out);
        v = {2'h0, divider_out[5:0]};
        count(200);
        chk("low stages", v, {2'h0, divider_out[5:0]});
        wr(0, 8'h19);
        wait_mode(slow_run_dual, 300);
        wr(0, 8'h18);
        wait_mode(fast_run_dual, 300);
    endtask

    initial begin
        mclk_in = 0;
        rst_in = 1;
        osc_cnt = 0;
        high_freq_clock_in = 0;
        low_freq_clock_in = 0;
        reg_addr_in = 0;
        reg_wdata_in = 0;
        reg_write_in = 0;
        reg_read_in = 0;
        irq_req_in = 0;
        master_irq_enable_in = 0;
        tbase_irq_individual_enable_in = 0;
        stop_req_in = 0;
        stop_release_in = 0;
        fails = 0;
        cmp_count = 0;
        repeat (6) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_reset;
        t_fast_cycle;
        t_doze(1'b1);
        t_doze(1'b0);
        t_deep(1'b1);
        t_deep(1'b0);
        t_stop;
        t_dual;
        end_sim;
    end
    // whole run is near 8000 cycles
    initial begin
        #400000;
        fails++;
        end_sim;
    end
endmodule

bind sclkm_top sclkm_top_sva u_sva (.mclk_in(mclk_in), .rst_in(rst_in), .machine_state_out(machine_state_out),
    .core_run_out(core_run_out), .periph_run_out(periph_run_out), .tbase_run_out(tbase_run_out),
    .fast_osc_on_out(fast_osc_on_out), .slow_pins_port_out(slow_pins_port_out), .divider_out(divider_out),
    .mode_out(mode_out), .tbase_irq_latch_out(tbase_irq_latch_out));
`default_nettype wire
